// ### tb/erxhw_checker.sv
/* erxhw_checker: port-level timing of hash table, watermarks and flow control.
   Assumes it is bound into erxhw_top and sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module erxhw_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// apb slave
	input wire erxhw_pkg::erxhw_apb_req_t apb_req,
	input wire erxhw_pkg::erxhw_apb_rsp_t apb_rsp,
	// receive side
	input wire logic [7:0] rx_packet_count,
	input wire logic [63:0] hash_table_bits,
	input wire logic hash_filter_active,
	input wire logic flow_ctrl,
	input wire logic irq
);
	import erxhw_pkg::*;
	logic wr, rd, lvl_f, lvl_e;
	logic [7:0] pa, full_q, empty_q;
	logic [31:0] pd;
	logic [2:0] ctl_q;
	logic [1:0] msk_q;
	// strobes and levels; levels follow the shadowed settings
	assign pa = apb_req.paddr;
	assign pd = apb_req.pwdata;
	assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd = apb_req.psel & apb_req.penable & !apb_req.pwrite;
	assign lvl_f = ctl_q[CTRL_RX_EN_BIT] && (rx_packet_count >= full_q);
	assign lvl_e = ctl_q[CTRL_RX_EN_BIT] && (rx_packet_count <= empty_q);
	// shadow settings, taken on the same edge the slave takes a write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			full_q <= 8'h00;
			empty_q <= 8'h00;
			ctl_q <= 3'h0;
			msk_q <= 2'h0;
		end else if (wr) begin
			if (pa == ADDR_WMARK) begin
				full_q <= pd[23:16];
				empty_q <= pd[7:0];
			end
			if (pa == ADDR_CTRL) begin
				ctl_q <= pd[2:0];
			end
			if (pa == ADDR_IRQ_MASK) begin
				msk_q <= pd[1:0];
			end
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	sequence s_irq;
		##[1:3] irq;
	endsequence
	property p_hash_lo;
		wr && pa == ADDR_HASH_LO && !hash_filter_active |=> hash_table_bits[31:0] == $past(pd);
	endproperty
	a_hash_lo: assert property (p_hash_lo) else $error("low word not written");
	property p_hash_hi;
		wr && pa == ADDR_HASH_HI && !hash_filter_active |=> hash_table_bits[63:32] == $past(pd);
	endproperty
	a_hash_hi: assert property (p_hash_hi) else $error("high word not written");
	property p_wm_fields;
		rd && pa == ADDR_WMARK |-> apb_rsp.prdata[23:16] == full_q && apb_rsp.prdata[7:0] == empty_q;
	endproperty
	a_wm_fields: assert property (p_wm_fields) else $error("mark fields wrong");
	property p_wm_zero;
		rd && pa == ADDR_WMARK |-> apb_rsp.prdata[31:24] == 8'h00 && apb_rsp.prdata[15:8] == 8'h00;
	endproperty
	a_wm_zero: assert property (p_wm_zero) else $error("unused mark bits set");
	property p_fc_on;
		ctl_q[CTRL_AUTO_FC_BIT] && lvl_f |=> flow_ctrl;
	endproperty
	a_fc_on: assert property (p_fc_on) else $error("flow control not on");
	property p_fc_off;
		ctl_q[CTRL_AUTO_FC_BIT] && lvl_e && !lvl_f |=> !flow_ctrl;
	endproperty
	a_fc_off: assert property (p_fc_off) else $error("flow control not off");
	property p_full_evt;
		$rose(lvl_f) && msk_q[IRQ_FULL_BIT] |-> s_irq;
	endproperty
	a_full_evt: assert property (p_full_evt) else $error("no full event");
	property p_empty_evt;
		$rose(lvl_e) && msk_q[IRQ_EMPTY_BIT] |-> s_irq;
	endproperty
	a_empty_evt: assert property (p_empty_evt) else $error("no empty event");
endmodule : erxhw_checker
bind erxhw_top erxhw_checker chk_u (.mclk(mclk), .arst_n(arst_n), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .rx_packet_count(rx_packet_count), .hash_table_bits(hash_table_bits),
	.hash_filter_active(hash_filter_active), .flow_ctrl(flow_ctrl), .irq(irq));
`default_nettype wire

// ### tb/testbench.sv
/* testbench: register, lock and watermark scenarios for erxhw_top over APB.
   Assumes a 100 MHz clock and the checker bound from its own file. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import erxhw_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	erxhw_apb_req_t req = '0;
	erxhw_apb_rsp_t rsp;
	logic [7:0] cnt = 8'h00;
	logic [63:0] ht;
	logic hfa, fc, irq;
	int fails = 0;
	int num_checks = 0;
	// 100 MHz clock
	always #5 mclk = ~mclk;
	erxhw_top dut_u (.mclk(mclk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
		.rx_packet_count(cnt), .hash_table_bits(ht), .hash_filter_active(hfa),
		.flow_ctrl(fc), .irq(irq));
	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; the wait is bounded so a stuck slave ends the run
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge mclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge mclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			conclude();
		end
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		xfer(1'b0, a, 32'h0000_0000, r, e);
		chk({32'h0000_0000, r}, {32'h0000_0000, x});
	endtask : rd
	// main sequence
	initial begin
		logic [31:0] r;
		logic e;
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		rd(ADDR_HASH_HI, 32'h0000_0000);
		rd(ADDR_WMARK, 32'h0000_0000);
		chk({63'h0, hfa}, 64'h0000_0000_0000_0000);
		wr(ADDR_HASH_LO, 32'hA5A5_0F0F);
		wr(ADDR_HASH_HI, 32'h1234_5678);
		rd(ADDR_HASH_LO, 32'hA5A5_0F0F);
		rd(ADDR_HASH_HI, 32'h1234_5678);
		chk(ht, 64'h1234_5678_A5A5_0F0F);
		wr(ADDR_WMARK, 32'hFFFF_FFFF);
		rd(ADDR_WMARK, 32'h00FF_00FF);
		xfer(1'b0, 8'h40, 32'h0000_0000, r, e);
		chk({31'h0000_0000, e, r}, {31'h0000_0000, 1'b1, 32'h0000_0000});
		wr(ADDR_WMARK, 32'h0008_0002);
		wr(ADDR_IRQ_MASK, 32'h0000_0003);
		wr(ADDR_CTRL, 32'h0000_0007);
		wr(ADDR_HASH_LO, 32'hFFFF_FFFF);
		rd(ADDR_HASH_LO, 32'hA5A5_0F0F);
		chk({63'h0, hfa}, 64'h0000_0000_0000_0001);
		rd(ADDR_IRQ_STAT, 32'h0000_0006);
		wr(ADDR_IRQ_STAT, 32'h0000_0007);
		cnt <= 8'h09;
		repeat (2) @(posedge mclk);
		rd(ADDR_STATUS, 32'h0000_000B);
		chk({63'h0, fc}, 64'h0000_0000_0000_0001);
		rd(ADDR_IRQ_STAT, 32'h0000_0001);
		@(negedge mclk);
		chk({63'h0, irq}, 64'h0000_0000_0000_0001);
		@(posedge mclk);
		cnt <= 8'h01;
		repeat (2) @(posedge mclk);
		rd(ADDR_STATUS, 32'h0000_000C);
		chk({63'h0, fc}, 64'h0000_0000_0000_0000);
		rd(ADDR_IRQ_STAT, 32'h0000_0003);
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		@(negedge mclk);
		chk({63'h0, irq}, 64'h0000_0000_0000_0000);
		wr(ADDR_IRQ_STAT, 32'h0000_0007);
		rd(ADDR_IRQ_STAT, 32'h0000_0000);
		conclude();
	end
endmodule : testbench
`default_nettype wire

// ### verilog/erxhw_pkg.sv
/*
 * erxhw_pkg: register map, field layout and carrier types of the receive
 * hash-table and watermark block.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
`default_nettype none
package erxhw_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_HASH_LO = 8'h00;
	localparam logic [7:0] ADDR_HASH_HI = 8'h04;
	localparam logic [7:0] ADDR_WMARK = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// watermark field positions
	localparam int WM_FULL_LSB = 16;
	localparam int WM_EMPTY_LSB = 0;
	localparam int WM_WIDTH = 8;
	// control register bits
	localparam int CTRL_RX_EN_BIT = 0;
	localparam int CTRL_HASH_EN_BIT = 1;
	localparam int CTRL_AUTO_FC_BIT = 2;
	// interrupt status and mask bits
	localparam int IRQ_FULL_BIT = 0;
	localparam int IRQ_EMPTY_BIT = 1;
	localparam int IRQ_LOCK_BIT = 2;
	localparam int IRQ_WIDTH = 3;
	// status register bits
	localparam int STAT_FC_BIT = 0;
	localparam int STAT_FULL_BIT = 1;
	localparam int STAT_EMPTY_BIT = 2;
	localparam int STAT_LOCK_BIT = 3;
	// reset values
	localparam logic [31:0] HASH_RESET = 32'h0000_0000;
	localparam logic [7:0] WM_RESET = 8'h00;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

	// apb request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} erxhw_apb_req_t;

	// apb response to the master
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} erxhw_apb_rsp_t;

	// software watermark settings
	typedef struct packed {
		logic [7:0] full_mark;
		logic [7:0] empty_mark;
	} erxhw_marks_t;
endpackage : erxhw_pkg
`default_nettype wire

// ### verilog/erxhw_top.sv
/*
 * erxhw_top: receive hash table, watermark register, control, interrupt
 * and status registers behind an APB slave.
 * Assumes APB master on mclk; rx_packet_count is synchronous to mclk.
 */
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module erxhw_top (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// apb slave
	input wire erxhw_pkg::erxhw_apb_req_t apb_req,
	output erxhw_pkg::erxhw_apb_rsp_t apb_rsp,
	// receive side
	input wire logic [7:0] rx_packet_count,
	output logic [63:0] hash_table_bits,
	output logic hash_filter_active,
	output logic flow_ctrl,
	// interrupt
	output logic irq
);
	import erxhw_pkg::*;

	logic [31:0] hash_lo_q;
	logic [31:0] hash_hi_q;
	erxhw_marks_t marks_q;
	logic receive_enable_q;
	logic hash_filter_enable_q;
	logic auto_fc_q;
	logic [IRQ_WIDTH-1:0] irq_stat_q;
	logic [IRQ_WIDTH-1:0] irq_stat_d;
	logic [IRQ_WIDTH-1:0] irq_mask_q;
	logic [IRQ_WIDTH-1:0] irq_events;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic wr_en;
	logic rd_en;
	logic hash_locked;
	logic hash_wr;
	logic lock_violation;
	logic full_level;
	logic empty_level;
	logic full_level_event;
	logic empty_level_event;
	logic flow_ctrl_w;

	// address decode used only by the error flag, for both reads and writes
	function automatic logic addr_mapped(input logic [7:0] a);
		if (a == ADDR_HASH_LO) begin
			addr_mapped = 1'b1;
		end else if (a == ADDR_HASH_HI) begin
			addr_mapped = 1'b1;
		end else if (a == ADDR_WMARK) begin
			addr_mapped = 1'b1;
		end else if (a == ADDR_CTRL) begin
			addr_mapped = 1'b1;
		end else if (a == ADDR_IRQ_STAT) begin
			addr_mapped = 1'b1;
		end else if (a == ADDR_IRQ_MASK) begin
			addr_mapped = 1'b1;
		end else if (a == ADDR_STATUS) begin
			addr_mapped = 1'b1;
		end else begin
			addr_mapped = 1'b0;
		end
	endfunction : addr_mapped

	// hash table halves, shared by the write gate and the refusal flag
	function automatic logic is_hash_addr(input logic [7:0] a);
		if (a == ADDR_HASH_LO) begin
			is_hash_addr = 1'b1;
		end else if (a == ADDR_HASH_HI) begin
			is_hash_addr = 1'b1;
		end else begin
			is_hash_addr = 1'b0;
		end
	endfunction : is_hash_addr

	// zero-wait slave: access phase completes in its first cycle
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

	// table is frozen while receive and hash filtering are both on
	assign hash_locked = receive_enable_q && hash_filter_enable_q;
	assign hash_wr = wr_en && !hash_locked && is_hash_addr(apb_req.paddr);
	// a refused table write is flagged rather than silently lost
	assign lock_violation = wr_en && hash_locked && is_hash_addr(apb_req.paddr);

	// hash table halves, written whole
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hash_lo_q <= HASH_RESET;
			hash_hi_q <= HASH_RESET;
		end else if (hash_wr) begin
			if (apb_req.paddr == ADDR_HASH_LO) begin
				hash_lo_q <= apb_req.pwdata;
			end else begin
				hash_hi_q <= apb_req.pwdata;
			end
		end
	end
	assign hash_table_bits = {hash_hi_q, hash_lo_q};

	// watermark fields; the reserved bytes have no storage at all
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			marks_q.full_mark <= WM_RESET;
			marks_q.empty_mark <= WM_RESET;
		end else if (wr_en && apb_req.paddr == ADDR_WMARK) begin
			marks_q.full_mark <= apb_req.pwdata[WM_FULL_LSB +: WM_WIDTH];
			marks_q.empty_mark <= apb_req.pwdata[WM_EMPTY_LSB +: WM_WIDTH];
		end
	end

	// control bits
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			receive_enable_q <= 1'b0;
			hash_filter_enable_q <= 1'b0;
			auto_fc_q <= 1'b0;
		end else if (wr_en && apb_req.paddr == ADDR_CTRL) begin
			receive_enable_q <= apb_req.pwdata[CTRL_RX_EN_BIT];
			hash_filter_enable_q <= apb_req.pwdata[CTRL_HASH_EN_BIT];
			auto_fc_q <= apb_req.pwdata[CTRL_AUTO_FC_BIT];
		end
	end
	// filtering only matters on the receive path
	assign hash_filter_active = receive_enable_q && hash_filter_enable_q;

	// comparators and flow-control latch
	erxhw_wmark u_wmark (
		.mclk(mclk),
		.arst_n(arst_n),
		.marks(marks_q),
		.auto_fc_en(auto_fc_q),
		.rx_en(receive_enable_q),
		.rx_packet_count(rx_packet_count),
		.full_level(full_level),
		.empty_level(empty_level),
		.full_level_event(full_level_event),
		.empty_level_event(empty_level_event),
		.flow_ctrl_q(flow_ctrl_w)
	);
	assign flow_ctrl = flow_ctrl_w;

	// sticky interrupt bits: write one clears, a new event wins
	assign irq_events[IRQ_FULL_BIT] = full_level_event;
	assign irq_events[IRQ_EMPTY_BIT] = empty_level_event;
	assign irq_events[IRQ_LOCK_BIT] = lock_violation;
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_en && apb_req.paddr == ADDR_IRQ_STAT) begin
			irq_stat_d = irq_stat_q & ~apb_req.pwdata[IRQ_WIDTH-1:0];
		end
		irq_stat_d = irq_stat_d | irq_events;
	end
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// interrupt mask
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_q <= '0;
		end else if (wr_en && apb_req.paddr == ADDR_IRQ_MASK) begin
			irq_mask_q <= apb_req.pwdata[IRQ_WIDTH-1:0];
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// read data registered in the setup cycle, ready in the access cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_q <= RDATA_UNMAPPED;
		end else if (rd_en) begin
			prdata_q <= RDATA_UNMAPPED;
			if (apb_req.paddr == ADDR_HASH_LO) begin
				prdata_q <= hash_lo_q;
			end else if (apb_req.paddr == ADDR_HASH_HI) begin
				prdata_q <= hash_hi_q;
			end else if (apb_req.paddr == ADDR_WMARK) begin
				// reserved bytes forced to zero
				prdata_q[WM_FULL_LSB +: WM_WIDTH] <= marks_q.full_mark;
				prdata_q[WM_EMPTY_LSB +: WM_WIDTH] <= marks_q.empty_mark;
			end else if (apb_req.paddr == ADDR_CTRL) begin
				prdata_q[CTRL_RX_EN_BIT] <= receive_enable_q;
				prdata_q[CTRL_HASH_EN_BIT] <= hash_filter_enable_q;
				prdata_q[CTRL_AUTO_FC_BIT] <= auto_fc_q;
			end else if (apb_req.paddr == ADDR_IRQ_STAT) begin
				prdata_q[IRQ_WIDTH-1:0] <= irq_stat_q;
			end else if (apb_req.paddr == ADDR_IRQ_MASK) begin
				prdata_q[IRQ_WIDTH-1:0] <= irq_mask_q;
			end else if (apb_req.paddr == ADDR_STATUS) begin
				prdata_q[STAT_FC_BIT] <= flow_ctrl_w;
				prdata_q[STAT_FULL_BIT] <= full_level;
				prdata_q[STAT_EMPTY_BIT] <= empty_level;
				prdata_q[STAT_LOCK_BIT] <= hash_locked;
			end
		end
	end

	// error flag for unmapped addresses, taken in the setup cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr_q <= 1'b0;
		end else if (apb_req.psel && !apb_req.penable) begin
			pslverr_q <= !addr_mapped(apb_req.paddr);
		end
	end

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = pslverr_q && apb_req.psel && apb_req.penable;
	assign apb_rsp.prdata = prdata_q;
endmodule : erxhw_top
`default_nettype wire

// ### verilog/erxhw_wmark.sv
/*
 * erxhw_wmark: full and empty watermark comparators and the automatic
 * flow-control latch.
 * Assumes a receive packet count on the same clock as the registers.
 */
`timescale 1ns/10ps
`default_nettype none
module erxhw_wmark (
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// settings
	input wire erxhw_pkg::erxhw_marks_t marks,
	input wire logic auto_fc_en,
	input wire logic rx_en,
	input wire logic [7:0] rx_packet_count,
	// results
	output logic full_level,
	output logic empty_level,
	output logic full_level_event,
	output logic empty_level_event,
	output logic flow_ctrl_q
);
	import erxhw_pkg::*;

	logic full_q;
	logic empty_q;

	// level conditions; receive path only, transmit never looks here
	assign full_level = rx_en && (rx_packet_count >= marks.full_mark);
	assign empty_level = rx_en && (rx_packet_count <= marks.empty_mark);

	// edge of each condition makes a one-cycle event
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			full_q <= 1'b0;
			empty_q <= 1'b0;
		end else begin
			full_q <= full_level;
			empty_q <= empty_level;
		end
	end
	assign full_level_event = full_level && !full_q;
	assign empty_level_event = empty_level && !empty_q;

	// flow control: on at full, off at empty; full wins if marks overlap
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flow_ctrl_q <= 1'b0;
		end else if (!auto_fc_en) begin
			flow_ctrl_q <= 1'b0;
		end else if (full_level) begin
			flow_ctrl_q <= 1'b1;
		end else if (empty_level) begin
			flow_ctrl_q <= 1'b0;
		end
	end
endmodule : erxhw_wmark
`default_nettype wire
